//--- common/band_line_pkg.sv
// Constants, register map and carrier types of the band and line select control.
// Assumes a single 25 MHz clock and an Avalon-MM slave with 32-bit data.
package band_line_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 25_000_000;
  localparam int LINE_SETTLE_US = 10_000;
  localparam int LINE_SETTLE_CYC = LINE_SETTLE_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CHAN  = 10;
  localparam int NUM_BAND  = 10;  // Nine filters plus the wideband through path.
  localparam int NUM_LINE  = 4;
  localparam logic [3:0] BAND_WB = 4'h9;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_STAT     = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h10;
  localparam logic [7:0] ADDR_MTX      = 8'h40;  // Ten words, one per channel line.

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_REMOTE = 0;
  localparam int CTRL_AUTO   = 1;
  localparam int CTRL_LINE   = 4;   // Two bits, panel line index 0..3.
  localparam int CTRL_BAND   = 8;   // Four bits, panel band index 0..9.
  localparam int MTX_BAND    = 0;   // Four bits, band index.
  localparam int MTX_LINE2   = 4;   // Line 2 column.
  localparam int MTX_LINE3   = 5;   // Line 3 column.
  localparam int EV_DONE     = 0;
  localparam int EV_FAULT    = 1;
  localparam int EV_READY    = 2;
  localparam int NUM_EV      = 3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [5:0] MTX_RST  = 6'h00;

  // Upper frequency edges of bands 0 to 8, in units of 100 kHz.
  localparam logic [9:0] BAND_EDGE [9] = '{10'h016, 10'h01F, 10'h02B, 10'h03C,
                                           10'h052, 10'h072, 10'h09E, 10'h0DC, 10'h12C};

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       read;
    logic       write;
    logic [7:0] address;
    logic [31:0] writedata;
  } avm_req_t;

  typedef struct packed {
    logic [3:0] band;
    logic [1:0] line;
    logic       auto_line;
    logic       remote;
  } ctrl_t;

  typedef enum {ST_IDLE, ST_MOVE, ST_LINE} sel_state_t;

endpackage

//--- rtl/band_line_ctrl.sv
// Band and line select control of a switched harmonic filter unit.
// Assumes synchronous inputs, a motor drive that reports band position, and an Avalon-MM master.
// How it works
// - Two programmed bits pick line: none 1, first 2, second 3, both 4.
// - Remote mode takes band and line from the external command inputs; the drive variant with manual pick takes line from the panel.
// - Local mode ignores external band and line commands, except the switching unit line under automatic pick.
// - Local mode lets the panel choose band and, with manual pick, line directly.
// - Band lamps show the band switch position; line lamps show the selected line.
// - Matrix variant maps each active channel line through the installed table.
// - Mute stays asserted while band or line selection is in progress.
// - Mute is asserted whenever the internal supply fault input is active.
// - A supply fault also raises the fault output to the drive unit.
// - Manual line selection raises the manual signal and uses panel line, or the table line in remote mode of the matrix variant.
// - Automatic line selection keeps manual low so the switching unit chooses.
// - Ready rises only after coarse tune initiate and the correct band.
// - Local mode with automatic pick hands line control to the switching unit.
// - Drive variant decodes frequency data into one of nine filter bands or the wideband path.
// - Local and remote modes exclude each other.
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
module band_line_ctrl
  import band_line_pkg::*;
#(
  parameter bit DRIVE_VARIANT = 1'b0,
  parameter int LINE_SETTLE   = LINE_SETTLE_CYC
) (
  // Clock and reset.
  input  wire logic                      mclk_i,
  input  wire logic                      rst_i,
  // Avalon-MM slave.
  input  band_line_pkg::avm_req_t        avm_i,
  output logic                           waitrequest_o,
  output logic [31:0]                    readdata_o,
  output logic                           irq_o,
  // External commands.
  input  wire logic [NUM_CHAN-1:0]       chan_sel_i,
  input  wire logic [11:0]               freq_code_i,
  input  wire logic                      tune_init_i,
  input  wire logic [1:0]                lsu_line_i,
  input  wire logic                      psu_fault_i,
  // Band switch feedback.
  input  wire logic [3:0]                band_pos_i,
  input  wire logic                      band_aligned_i,
  // Outputs to amplifier, drive unit, switching unit and lamps.
  output logic [NUM_BAND-1:0]            band_req_o,
  output logic [NUM_LINE-1:0]            line_sel_o,
  output logic                           mute_o,
  output logic                           fault_o,
  output logic                           ready_o,
  output logic                           manual_o,
  output logic [NUM_BAND-1:0]            band_lamp_o,
  output logic [NUM_LINE-1:0]            line_lamp_o
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (LINE_SETTLE < 1 || LINE_SETTLE > 24'hFFFFFF) begin : g_bad
    $error("LINE_SETTLE out of range");
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // One-hot of a band index; out-of-range codes give all zero.
  function automatic logic [NUM_BAND-1:0] band_oh(input logic [3:0] b);
    band_oh = '0;
    if (b < 4'hA) begin
      band_oh[b] = 1'b1;
    end
  endfunction

  function automatic logic [NUM_LINE-1:0] line_oh(input logic [1:0] l);
    line_oh = '0;
    line_oh[l] = 1'b1;
  endfunction

  // Inverted nines complement hundreds and tens, inverted 100 kHz units digit.
  function automatic logic [3:0] freq_band(input logic [11:0] f);
    logic [9:0] khz;
    khz = 10'(10'd100 * (10'd9 - 10'(~f[11:8] & 4'hF)))
        + 10'(10'd10 * (10'd9 - 10'(~f[7:4] & 4'hF)))
        + 10'(~f[3:0] & 4'hF);
    freq_band = BAND_WB;
    for (int i = 8; i >= 0; i--) begin
      if (khz < BAND_EDGE[i]) begin
        freq_band = 4'(i);
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  ctrl_t                ctrl_q;
  logic [5:0]           mtx_q [NUM_CHAN];
  logic [NUM_EV-1:0]    irq_stat_q;
  logic [NUM_EV-1:0]    irq_en_q;
  logic                 ack_q;
  sel_state_t           state_q;
  logic [3:0]           band_q;
  logic [1:0]           line_q;
  logic [23:0]          cnt_q;
  logic                 tune_q;
  logic [3:0]           tgt_band;
  logic [1:0]           tgt_line;
  logic [5:0]           mtx_sel;
  logic                 pend;
  logic                 wr_ok;
  logic [NUM_EV-1:0]    ev;

  // ----------------------------------------------------------------
  // Target selection
  // ----------------------------------------------------------------
  // Picks the matrix word of the active channel line.
  always_comb begin
    mtx_sel = MTX_RST;
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (chan_sel_i[c]) begin
        mtx_sel = mtx_sel | mtx_q[c];
      end
    end
  end

  // Chooses band and line from the panel or the external commands.
  always_comb begin
    if (ctrl_q.remote) begin
      if (DRIVE_VARIANT) begin
        tgt_band = freq_band(freq_code_i);
      end else begin
        tgt_band = mtx_sel[MTX_BAND +: 4];
      end
    end else begin
      tgt_band = ctrl_q.band;
    end
    if (ctrl_q.auto_line) begin
      tgt_line = lsu_line_i;
    end else if (ctrl_q.remote && !DRIVE_VARIANT) begin
      tgt_line = {mtx_sel[MTX_LINE3], mtx_sel[MTX_LINE2]};
    end else begin
      tgt_line = ctrl_q.line;
    end
  end

  assign pend = (tgt_band != band_q) || (tgt_line != line_q);
  assign wr_ok = avm_i.write && ack_q;

  // ----------------------------------------------------------------
  // Selection sequencer
  // ----------------------------------------------------------------
  // Requests a band, waits for the switch to align, then lets the relays settle.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      band_q  <= 4'h0;
      line_q  <= 2'h0;
      cnt_q   <= 24'h000000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (pend) begin
            band_q  <= tgt_band;
            line_q  <= tgt_line;
            state_q <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          if (band_pos_i == band_q && band_aligned_i) begin
            cnt_q   <= 24'(LINE_SETTLE - 1);
            state_q <= ST_LINE;
          end
        end
        default: begin
          if (cnt_q == 24'h000000) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 24'h000001;
          end
        end
      endcase
    end
  end

  // Catches coarse tune initiate; a new band request clears it, a pulse wins.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tune_q <= 1'b0;
    end else if (tune_init_i) begin
      tune_q <= 1'b1;
    end else if (state_q == ST_IDLE && tgt_band != band_q) begin
      tune_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Drives relays, mute, fault, ready, manual and lamps from flip-flops.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      band_req_o  <= '0;
      line_sel_o  <= '0;
      mute_o      <= 1'b1;
      fault_o     <= 1'b0;
      ready_o     <= 1'b0;
      manual_o    <= 1'b1;
      band_lamp_o <= '0;
      line_lamp_o <= '0;
    end else begin
      band_req_o  <= band_oh(band_q);
      line_sel_o  <= line_oh(line_q);
      mute_o      <= (state_q != ST_IDLE) || pend || psu_fault_i;
      fault_o     <= psu_fault_i;
      ready_o     <= tune_q && state_q != ST_MOVE && !(state_q == ST_IDLE && tgt_band != band_q)
                     && band_pos_i == band_q;
      manual_o    <= !ctrl_q.auto_line;
      band_lamp_o <= band_oh(band_pos_i);
      line_lamp_o <= line_oh(line_q);
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign ev[EV_DONE]  = state_q == ST_LINE && cnt_q == 24'h000000;
  assign ev[EV_FAULT] = psu_fault_i && !fault_o;
  assign ev[EV_READY] = ready_o;

  // Sticky status; an event in the clearing cycle survives.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_stat_q <= '0;
      irq_o      <= 1'b0;
    end else begin
      if (wr_ok && avm_i.address == ADDR_IRQ_CLR) begin
        irq_stat_q <= (irq_stat_q & ~avm_i.writedata[NUM_EV-1:0]) | ev;
      end else begin
        irq_stat_q <= irq_stat_q | ev;
      end
      irq_o <= |(irq_stat_q & irq_en_q);
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------
  // Answers every access on the second cycle; waitrequest falls for one cycle.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ack_q         <= 1'b0;
      waitrequest_o <= 1'b1;
    end else begin
      ack_q         <= (avm_i.read || avm_i.write) && !ack_q;
      waitrequest_o <= !((avm_i.read || avm_i.write) && !ack_q);
    end
  end

  // Writable registers; one mode bit keeps local and remote exclusive.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ctrl_q   <= ctrl_t'(CTRL_RST);
      irq_en_q <= '0;
    end else if (wr_ok) begin
      if (avm_i.address == ADDR_CTRL) begin
        ctrl_q.remote    <= avm_i.writedata[CTRL_REMOTE];
        ctrl_q.auto_line <= avm_i.writedata[CTRL_AUTO];
        ctrl_q.line      <= avm_i.writedata[CTRL_LINE +: 2];
        ctrl_q.band      <= avm_i.writedata[CTRL_BAND +: 4];
      end else if (avm_i.address == ADDR_IRQ_EN) begin
        irq_en_q <= avm_i.writedata[NUM_EV-1:0];
      end
    end
  end

  // Channel table, filled at installation.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        mtx_q[c] <= MTX_RST;
      end
    end else begin
      for (int c = 0; c < NUM_CHAN; c++) begin
        if (wr_ok && avm_i.address == 8'(ADDR_MTX + 4 * c)) begin
          mtx_q[c] <= avm_i.writedata[5:0];
        end
      end
    end
  end

  // Read data is loaded as waitrequest falls; unmapped addresses read zero.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      readdata_o <= 32'h00000000;
    end else if (avm_i.read && !ack_q) begin
      readdata_o <= 32'h00000000;
      if (avm_i.address == ADDR_CTRL) begin
        readdata_o <= {20'h00000, ctrl_q.band, 2'b00, ctrl_q.line, 2'b00, ctrl_q.auto_line, ctrl_q.remote};
      end else if (avm_i.address == ADDR_STAT) begin
        readdata_o <= {16'h0000, band_pos_i, 2'b00, line_q, 1'b0, state_q != ST_IDLE,
                       manual_o, ready_o, fault_o, mute_o, 2'b00};
      end else if (avm_i.address == ADDR_IRQ_STAT) begin
        readdata_o <= {29'h00000000, irq_stat_q};
      end else if (avm_i.address == ADDR_IRQ_EN) begin
        readdata_o <= {29'h00000000, irq_en_q};
      end else begin
        for (int c = 0; c < NUM_CHAN; c++) begin
          if (avm_i.address == 8'(ADDR_MTX + 4 * c)) begin
            readdata_o <= {26'h0000000, mtx_q[c]};
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  a_line_decode: assert property (state_q == ST_LINE |-> line_sel_o == line_oh(line_q))
    else $error("line outputs do not match decoded line");
  a_band_follow: assert property (state_q == ST_IDLE && !pend ##1 state_q == ST_IDLE
                                  |-> band_req_o == band_oh($past(tgt_band)))
    else $error("band request does not follow selected source");
  a_band_lamp: assert property ($changed(band_pos_i) |=> band_lamp_o == band_oh($past(band_pos_i)))
    else $error("band lamp lags feedback");
  a_mute_busy: assert property (state_q == ST_MOVE |=> mute_o)
    else $error("amplifier not muted during selection");
  a_mute_fault: assert property (psu_fault_i |=> mute_o && fault_o)
    else $error("supply fault not reported");
  a_manual_line: assert property ($changed(ctrl_q.auto_line) |=> manual_o == !$past(ctrl_q.auto_line))
    else $error("manual signal wrong");
  a_ready_cause: assert property ($rose(ready_o) |-> $past(tune_q) && band_pos_i == band_q)
    else $error("ready without tune initiate or band");
  a_ready_move: assert property (state_q == ST_MOVE ##1 state_q == ST_MOVE |-> !ready_o)
    else $error("ready while band moving");
  a_mute_release: assert property ($fell(mute_o) |-> band_lamp_o == band_req_o && state_q == ST_IDLE)
    else $error("mute released before band reached");

  c_remote_move: cover property (ctrl_q.remote && state_q == ST_IDLE ##1 state_q == ST_MOVE);
  c_fault: cover property ($rose(fault_o));
  c_ready: cover property ($rose(ready_o));

endmodule

//--- testbench/band_drive_model.sv
// Far side model: band switch motor with position feedback and the line switching unit.
// Assumes one-hot band requests from the control block and its ready output.
`timescale 1ns/1ns
module band_drive_model
  import band_line_pkg::*;
#(
  parameter int MOVE_CYC = 6
) (
  // Clock and reset.
  input  wire logic                mclk_i,
  input  wire logic                rst_i,
  // From the control block.
  input  wire logic [NUM_BAND-1:0] band_req_i,
  input  wire logic                ready_i,
  input  wire logic [1:0]          best_line_i,
  // To the control block.
  output logic [3:0]               band_pos_o,
  output logic                     band_aligned_o,
  output logic [1:0]               lsu_line_o
);
  int tgt;
  int cur;
  int cnt;

  // Finds the requested band index, or -1 when nothing is requested.
  always_comb begin
    tgt = -1;
    for (int i = 0; i < NUM_BAND; i++) begin
      if (band_req_i[i]) begin
        tgt = i;
      end
    end
  end

  // Motor: while moving the wiper wanders and aligned stays low, so a stale position never passes.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cur <= 0;
      cnt <= 0;
      band_pos_o <= 4'h0;
      band_aligned_o <= 1'b1;
    end else if (tgt >= 0 && tgt != cur) begin
      band_aligned_o <= 1'b0;
      band_pos_o <= 4'(cnt % NUM_BAND);
      cnt <= cnt + 1;
      if (cnt == MOVE_CYC) begin
        cur <= tgt;
        cnt <= 0;
        band_pos_o <= 4'(tgt);
        band_aligned_o <= 1'b1;
      end
    end
  end

  // Switching unit picks its best line only while ready is high.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lsu_line_o <= 2'h0;
    end else if (ready_i) begin
      lsu_line_o <= best_line_i;
    end
  end
endmodule

//--- testbench/testbench.sv
// Self-checking bench of the band and line select control, matrix and drive variants.
// Assumes the far side model file and the package are compiled first.
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  import band_line_pkg::*;
  localparam int SETTLE = 4;
  logic                mclk_i = 1'b0;
  logic                rst_i = 1'b1;
  avm_req_t            avm = '0;
  logic                waitrequest_o, irq_o, mute_o, fault_o, ready_o, manual_o, band_aligned_i;
  logic [31:0]         readdata_o;
  logic [NUM_CHAN-1:0] chan_sel_i = '0;
  logic                tune_init_i = 1'b0;
  logic                psu_fault_i = 1'b0;
  logic [1:0]          lsu_line_i, best_line = 2'h0;
  logic [3:0]          band_pos_i;
  logic [NUM_BAND-1:0] band_req_o, band_lamp_o;
  logic [NUM_LINE-1:0] line_sel_o, line_lamp_o;
  logic [31:0]         q;
  int                  mismatches = 0;
  int                  total_checks = 0;
  int                  mtx_band [NUM_CHAN];
  int                  ch, rb;
  int                  fq;
  // Upper band edges in 100 kHz steps; at or above the last edge the wideband path is chosen.
  int                  band_edge [$] = '{22, 31, 43, 60, 82, 114, 158, 220, 300};
  logic [11:0]         freq = 12'hFFF;
  logic                mute_2, ready_2, band_aligned_2;
  logic [1:0]          lsu_line_2;
  logic [3:0]          band_pos_2;
  logic [NUM_BAND-1:0] band_req_2, band_lamp_2;

  // ----------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------
  always #20 mclk_i = ~mclk_i;

  band_line_ctrl #(.DRIVE_VARIANT(1'b0), .LINE_SETTLE(SETTLE)) dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .avm_i(avm), .waitrequest_o(waitrequest_o),
    .readdata_o(readdata_o), .irq_o(irq_o), .chan_sel_i(chan_sel_i), .freq_code_i(12'hFFF),
    .tune_init_i(tune_init_i), .lsu_line_i(lsu_line_i), .psu_fault_i(psu_fault_i),
    .band_pos_i(band_pos_i), .band_aligned_i(band_aligned_i), .band_req_o(band_req_o),
    .line_sel_o(line_sel_o), .mute_o(mute_o), .fault_o(fault_o), .ready_o(ready_o),
    .manual_o(manual_o), .band_lamp_o(band_lamp_o), .line_lamp_o(line_lamp_o));

  band_drive_model #(.MOVE_CYC(6)) far (
    .mclk_i(mclk_i), .rst_i(rst_i), .band_req_i(band_req_o), .ready_i(ready_o),
    .best_line_i(best_line), .band_pos_o(band_pos_i), .band_aligned_o(band_aligned_i),
    .lsu_line_o(lsu_line_i));

  // Frequency decoder variant on the same bus and inputs, with its own band switch.
  band_line_ctrl #(.DRIVE_VARIANT(1'b1), .LINE_SETTLE(SETTLE)) dut_drv (
    .mclk_i(mclk_i), .rst_i(rst_i), .avm_i(avm), .waitrequest_o(), .readdata_o(), .irq_o(),
    .chan_sel_i(chan_sel_i), .freq_code_i(freq), .tune_init_i(tune_init_i), .lsu_line_i(lsu_line_2),
    .psu_fault_i(psu_fault_i), .band_pos_i(band_pos_2), .band_aligned_i(band_aligned_2),
    .band_req_o(band_req_2), .line_sel_o(), .mute_o(mute_2), .fault_o(), .ready_o(ready_2),
    .manual_o(), .band_lamp_o(band_lamp_2), .line_lamp_o());

  band_drive_model #(.MOVE_CYC(6)) far_drv (
    .mclk_i(mclk_i), .rst_i(rst_i), .band_req_i(band_req_2), .ready_i(ready_2),
    .best_line_i(best_line), .band_pos_o(band_pos_2), .band_aligned_o(band_aligned_2),
    .lsu_line_o(lsu_line_2));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Expected band index of a frequency in 100 kHz steps; 9 is the wideband path.
  function automatic int exp_band(input int f);
    exp_band = 0;
    foreach (band_edge[i]) begin
      if (f >= band_edge[i]) begin
        exp_band = i + 1;
      end
    end
  endfunction

  // One Avalon access, held until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    avm.read <= ~wr;
    avm.write <= wr;
    avm.address <= a;
    avm.writedata <= d;
    do begin
      @(posedge mclk_i);
      n++;
    end while (waitrequest_o !== 1'b0);
    q = readdata_o;
    avm.read <= 1'b0;
    avm.write <= 1'b0;
    `CHK(n, 2)
  endtask

  // Checks the mute span of one selection and the settled outputs.
  task automatic sel_check(input int b, input int l);
    int n;
    n = 0;
    repeat (3) @(posedge mclk_i);
    `CHK(mute_o, 1'b1)
    while (mute_o === 1'b1) begin
      @(posedge mclk_i);
      n++;
    end
    `CHK(n >= SETTLE, 1'b1)
    `CHK(band_req_o, NUM_BAND'(1) << b)
    `CHK(line_sel_o, NUM_LINE'(1) << l)
    `CHK(band_lamp_o, NUM_BAND'(1) << b)
    `CHK(line_lamp_o, NUM_LINE'(1) << l)
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog against a hang.
  initial begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h73bdde02));
    repeat (5) @(posedge mclk_i);
    rst_i <= 1'b0;
    `CHK(mute_o, 1'b1)
    `CHK(manual_o, 1'b1)
    bus(1'b0, ADDR_CTRL, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b1, 8'hFC, 32'hFFFFFFFF);
    bus(1'b0, 8'hFC, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b0, ADDR_IRQ_CLR, 32'h0);
    `CHK(q, 32'h0)
    $display("test registers done");
    // Remote mode: each line code through the installed table, one channel line at a time.
    for (int k = 0; k < 4; k++) begin
      ch = k + 5 * ($urandom % 2);
      mtx_band[ch] = k + 1;
      bus(1'b1, ADDR_MTX + 8'(4 * ch), 32'(k + 1) | 32'(k % 2) << MTX_LINE2 | 32'(k / 2) << MTX_LINE3);
      chan_sel_i <= NUM_CHAN'(1) << ch;
      fq = 16 + $urandom % 300;
      freq <= ~{4'(9 - fq / 100), 4'(9 - fq / 10 % 10), 4'(fq % 10)};
      if (k == 0) begin
        bus(1'b1, ADDR_CTRL, 32'h1);
      end
      sel_check(mtx_band[ch], k);
      `CHK(band_req_2, NUM_BAND'(1) << exp_band(fq))
      `CHK(band_lamp_2, NUM_BAND'(1) << exp_band(fq))
      `CHK(mute_2, 1'b0)
    end
    $display("test remote done");
    // Local mode: panel wins over a moving channel command.
    rb = 5 + $urandom % 4;
    bus(1'b1, ADDR_CTRL, 32'(rb) << CTRL_BAND | 32'h2 << CTRL_LINE);
    chan_sel_i <= NUM_CHAN'(1) << 9;
    sel_check(rb, 2);
    `CHK(ready_o, 1'b0)
    $display("test local done");
    // Automatic line pick: ready after tune initiate, then the switching unit chooses.
    best_line <= 2'($urandom % 3) ^ 2'h3;
    bus(1'b1, ADDR_CTRL, 32'(rb) << CTRL_BAND | 32'h2 << CTRL_LINE | 32'h2);
    repeat (3) @(posedge mclk_i);
    `CHK(manual_o, 1'b0)
    `CHK(ready_o, 1'b0)
    tune_init_i <= 1'b1;
    @(posedge mclk_i);
    tune_init_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    `CHK(ready_o, 1'b1)
    sel_check(rb, int'(best_line));
    bus(1'b1, ADDR_CTRL, 32'(rb - 4) << CTRL_BAND);
    repeat (3) @(posedge mclk_i);
    `CHK(ready_o, 1'b0)
    `CHK(manual_o, 1'b1)
    repeat (40) @(posedge mclk_i);
    $display("test auto line done");
    // Supply fault: mute, fault output and a maskable interrupt.
    bus(1'b1, ADDR_IRQ_CLR, 32'h7);
    bus(1'b1, ADDR_IRQ_EN, 32'h2);
    for (int m = 0; m < 2; m++) begin
      psu_fault_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      `CHK(fault_o, 1'b1)
      `CHK(mute_o, 1'b1)
      `CHK(irq_o, m == 0)
      bus(1'b0, ADDR_IRQ_STAT, 32'h0);
      `CHK(q[EV_FAULT], 1'b1)
      psu_fault_i <= 1'b0;
      bus(1'b1, ADDR_IRQ_CLR, 32'h2);
      bus(1'b1, ADDR_IRQ_EN, 32'h0);
      repeat (3) @(posedge mclk_i);
      `CHK(irq_o, 1'b0)
      `CHK(fault_o, 1'b0)
      `CHK(mute_o, 1'b0)
    end
    $display("test fault done");
    end_of_test();
  end
endmodule
